// File: hdl/trc_pkg.sv
// How it works
// - run bit 0 counts; 0 stops and clears
// - prescaler bit 2 starts or stops prescaler
// - stopped counter reads last captured running value
// - run bits 1, 3..31 read zero, reset zero
// - idle bit 3: 0 halts in idle
// - sync bit 5: 1 waits common start
// - buffer bit 7 enables double buffering, reset 0
// - disabling channel keeps programmed register values
package trc_pkg;
  localparam int TRC_ADDR_W = 8;
  localparam int TRC_DATA_W = 32;
  localparam int TRC_CNT_W = 16;
  localparam int TRC_MODE_W = 7;
  localparam logic [7:0] TRC_OFS_ENABLE = 8'h00;
  localparam logic [7:0] TRC_OFS_RUN = 8'h04;
  localparam logic [7:0] TRC_OFS_CONFIG = 8'h08;
  localparam logic [7:0] TRC_OFS_MODE = 8'h0c;
  localparam logic [7:0] TRC_OFS_UPCNT = 8'h1c;
  localparam int TRC_EN_BIT = 0;
  localparam int TRC_RUN_BIT = 0;
  localparam int TRC_PRUN_BIT = 2;
  localparam int TRC_IDLE_BIT = 3;
  localparam int TRC_SYNC_BIT = 5;
  localparam int TRC_RSV6_BIT = 6;
  localparam int TRC_WBF_BIT = 7;
  localparam int TRC_MODE_RO_BIT = 5;
  localparam logic [31:0] TRC_ZERO = 32'h0000_0000;
  localparam logic [6:0] TRC_MODE_RST = 7'h20;
  localparam logic [15:0] TRC_CNT_ONE = 16'h0001;

  typedef struct packed {
    logic [TRC_CNT_W-1:0] count;
    logic [TRC_CNT_W-1:0] captured;
  } trc_cnt_state_t;
endpackage

// File: hdl/trc_cnt_if.sv
interface trc_cnt_if;
  import trc_pkg::*;
  logic run;
  logic advance;
  logic [TRC_CNT_W-1:0] count;
  logic [TRC_CNT_W-1:0] captured;
  modport ctl (output run, output advance, input count, input captured);
  modport cnt (input run, input advance, output count, output captured);
endinterface

// File: hdl/trc_counter.sv
module trc_counter
  import trc_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  trc_cnt_if.cnt cif
);
  trc_cnt_state_t state_reg;
  trc_cnt_state_t state_next;

  always_comb begin
    state_next = state_reg;
    if (!cif.run) begin
      state_next.count = TRC_ZERO[TRC_CNT_W-1:0];
    end else if (cif.advance) begin
      state_next.count = state_reg.count + TRC_CNT_ONE;
    end
    if (cif.run) begin
      state_next.captured = state_reg.count;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign cif.count = state_reg.count;
  assign cif.captured = state_reg.captured;
endmodule

// File: hdl/trc_top.sv
// Local design decisions: the placing of the registers and the plain strobed port.
module trc_top
  import trc_pkg::*;
(
  input wire logic CLK,
  input wire logic NRST,
  input wire logic [trc_pkg::TRC_ADDR_W-1:0] ADDR,
  input wire logic [trc_pkg::TRC_DATA_W-1:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [trc_pkg::TRC_DATA_W-1:0] RDATA,
  input wire logic COUNT_TICK,
  input wire logic IDLE_MODE,
  input wire logic SYNC_START,
  output logic COUNTER_RUN,
  output logic PRESCALER_RUN,
  output logic DOUBLE_BUFFER_EN,
  output logic [trc_pkg::TRC_CNT_W-1:0] COUNT_VALUE
);
  import trc_pkg::*;

  typedef struct packed {
    logic channel_enable;
    logic counter_run;
    logic prescaler_run;
    logic idle_operation;
    logic sync_start_mode;
    logic rsv6;
    logic double_buffer_enable;
    logic [TRC_MODE_W-1:0] mode;
    logic started;
    logic [TRC_DATA_W-1:0] rdata;
    logic cnt_run_out;
    logic pre_run_out;
  } trc_top_state_t;

  trc_top_state_t state_reg;
  trc_top_state_t state_next;
  trc_cnt_if cif ();
  logic hold;
  logic advance;

  trc_counter u_counter (
    .clk (CLK),
    .nrst (NRST),
    .cif (cif.cnt)
  );

  function automatic logic [TRC_DATA_W-1:0] bit_word(
    input logic value,
    input int pos
  );
    logic [TRC_DATA_W-1:0] w;
    w = TRC_ZERO;
    w[pos] = value;
    return w;
  endfunction

  // one halt test shared by the counter and the prescaler output
  function automatic logic idle_halt(
    input logic idle_mode,
    input logic idle_op
  );
    return idle_mode && !idle_op;
  endfunction

  // started drops with run, so a stopped sync channel must re-arm
  function automatic logic start_next(
    input logic started,
    input logic run,
    input logic sync_mode,
    input logic sync_in
  );
    logic s;
    s = started;
    if (!run) begin
      s = 1'b0;
    end else if (!sync_mode || sync_in) begin
      s = 1'b1;
    end
    return s;
  endfunction

  function automatic logic count_enable(
    input trc_top_state_t s,
    input logic tick,
    input logic halt
  );
    return tick && s.counter_run && s.started && !halt
      && s.channel_enable;
  endfunction

  function automatic logic [TRC_DATA_W-1:0] run_word(
    input trc_top_state_t s
  );
    return bit_word(s.counter_run, TRC_RUN_BIT)
      | bit_word(s.prescaler_run, TRC_PRUN_BIT);
  endfunction

  // bit 6 is stored as written; software is expected to keep it zero
  function automatic logic [TRC_DATA_W-1:0] config_word(
    input trc_top_state_t s
  );
    return bit_word(s.idle_operation, TRC_IDLE_BIT)
      | bit_word(s.sync_start_mode, TRC_SYNC_BIT)
      | bit_word(s.rsv6, TRC_RSV6_BIT)
      | bit_word(s.double_buffer_enable, TRC_WBF_BIT);
  endfunction

  function automatic logic [TRC_DATA_W-1:0] read_word(
    input trc_top_state_t s,
    input logic [TRC_ADDR_W-1:0] a,
    input logic [TRC_CNT_W-1:0] live,
    input logic [TRC_CNT_W-1:0] snap
  );
    logic [TRC_DATA_W-1:0] w;
    w = TRC_ZERO;
    if (a == TRC_OFS_ENABLE) begin
      w = bit_word(s.channel_enable, TRC_EN_BIT);
    end else if (!s.channel_enable) begin
      w = TRC_ZERO;
    end else begin
      case (a)
        TRC_OFS_RUN: begin
          w = run_word(s);
        end
        TRC_OFS_CONFIG: begin
          w = config_word(s);
        end
        TRC_OFS_MODE: begin
          w[TRC_MODE_W-1:0] = s.mode;
          w[TRC_MODE_RO_BIT] = 1'b1;
        end
        TRC_OFS_UPCNT: begin
          if (s.counter_run) begin
            w[TRC_CNT_W-1:0] = live;
          end else begin
            w[TRC_CNT_W-1:0] = snap;
          end
        end
        default: begin
          w = TRC_ZERO;
        end
      endcase
    end
    return w;
  endfunction

  always_comb begin
    state_next = state_reg;
    hold = 1'b0;
    advance = 1'b0;

    if (WR) begin
      if (ADDR == TRC_OFS_ENABLE) begin
        state_next.channel_enable = WDATA[TRC_EN_BIT];
      end else if (state_reg.channel_enable) begin
        case (ADDR)
          TRC_OFS_RUN: begin
            state_next.counter_run = WDATA[TRC_RUN_BIT];
            state_next.prescaler_run = WDATA[TRC_PRUN_BIT];
          end
          TRC_OFS_CONFIG: begin
            state_next.idle_operation = WDATA[TRC_IDLE_BIT];
            state_next.sync_start_mode = WDATA[TRC_SYNC_BIT];
            state_next.rsv6 = WDATA[TRC_RSV6_BIT];
            state_next.double_buffer_enable = WDATA[TRC_WBF_BIT];
          end
          TRC_OFS_MODE: begin
            state_next.mode = WDATA[TRC_MODE_W-1:0];
          end
          default: begin
            state_next.mode = state_reg.mode;
          end
        endcase
      end
    end

    if (RD) begin
      state_next.rdata = read_word(state_reg, ADDR, cif.count,
                                   cif.captured);
    end else begin
      state_next.rdata = TRC_ZERO;
    end

    // sync channels wait for common start
    state_next.started = start_next(state_reg.started,
      state_reg.counter_run, state_reg.sync_start_mode, SYNC_START);

    hold = idle_halt(IDLE_MODE, state_reg.idle_operation);

    // disabled channel gets no advance strobe, so the count freezes
    // count on tick while running
    advance = count_enable(state_reg, COUNT_TICK, hold);

    state_next.cnt_run_out = state_next.counter_run;
    state_next.pre_run_out = state_next.prescaler_run
      && !idle_halt(IDLE_MODE, state_next.idle_operation);
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      state_reg <= '0;
      state_reg.mode <= TRC_MODE_RST;
    end else begin
      state_reg <= state_next;
    end
  end

  assign cif.run = state_reg.counter_run;
  assign cif.advance = advance;

  assign RDATA = state_reg.rdata;
  assign COUNTER_RUN = state_reg.cnt_run_out;
  assign PRESCALER_RUN = state_reg.pre_run_out;
  assign DOUBLE_BUFFER_EN = state_reg.double_buffer_enable;
  assign COUNT_VALUE = cif.count;
endmodule

// File: verif/trc_top_props.sv
module trc_top_props
  import trc_pkg::*;
(
  input logic CLK,
  input logic NRST,
  input logic [TRC_ADDR_W-1:0] ADDR,
  input logic [TRC_DATA_W-1:0] WDATA,
  input logic WR,
  input logic RD,
  input logic [TRC_DATA_W-1:0] RDATA,
  input logic COUNT_TICK,
  input logic IDLE_MODE,
  input logic SYNC_START,
  input logic COUNTER_RUN,
  input logic PRESCALER_RUN,
  input logic DOUBLE_BUFFER_EN,
  input logic [TRC_CNT_W-1:0] COUNT_VALUE
);
  timeunit 1ns;
  timeprecision 1ps;
  logic en_reg;
  default clocking @(posedge CLK); endclocking
  default disable iff (!NRST);
  // mirror of the enable bit, so refused writes can be told apart
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST)
      en_reg <= 1'b0;
    else if (WR && ADDR == TRC_OFS_ENABLE)
      en_reg <= WDATA[TRC_EN_BIT];
  end
  sequence run_wr_s;
    WR && en_reg && ADDR == TRC_OFS_RUN;
  endsequence
  sequence cfg_wr_s;
    WR && en_reg && ADDR == TRC_OFS_CONFIG;
  endsequence
  run_follow_a: assert property (
    run_wr_s |=> COUNTER_RUN == $past(WDATA[TRC_RUN_BIT])) else $error("run");
  prun_follow_a: assert property (
    run_wr_s ##0 !IDLE_MODE ##1 !IDLE_MODE
    |-> PRESCALER_RUN == $past(WDATA[TRC_PRUN_BIT])) else $error("prun");
  buf_follow_a: assert property (
    cfg_wr_s |=> DOUBLE_BUFFER_EN == $past(WDATA[TRC_WBF_BIT]))
    else $error("wbf");
  run_locked_a: assert property (
    WR && !en_reg && ADDR == TRC_OFS_RUN |=> $stable(COUNTER_RUN))
    else $error("locked");
  stop_clear_a: assert property (
    !COUNTER_RUN [*2] |-> COUNT_VALUE == 16'h0000) else $error("clear");
  count_step_a: assert property (
    $changed(COUNT_VALUE) |-> COUNT_VALUE == 16'h0000
    || COUNT_VALUE == $past(COUNT_VALUE) + TRC_CNT_ONE) else $error("step");
  run_rd_zero_a: assert property (
    RD && ADDR == TRC_OFS_RUN |=> RDATA[31:3] == 29'h0000_0000 && !RDATA[1])
    else $error("run rsv");
  cfg_rd_zero_a: assert property (
    RD && ADDR == TRC_OFS_CONFIG |=> RDATA[31:8] == 24'h00_0000
    && !RDATA[4] && RDATA[2:0] == 3'h0) else $error("cfg rsv");
endmodule
bind trc_top trc_top_props u_trc_top_props (.CLK, .NRST, .ADDR, .WDATA, .WR,
  .RD, .RDATA, .COUNT_TICK, .IDLE_MODE, .SYNC_START, .COUNTER_RUN,
  .PRESCALER_RUN, .DOUBLE_BUFFER_EN, .COUNT_VALUE);

// File: verif/test_timer_run_control.sv
module test_timer_run_control;
  timeunit 1ns;
  timeprecision 1ps;
  import trc_pkg::*;
  logic clk, nrst, wr_en, rd_en, tick_in, idle_in, sync_in;
  logic run_o, prun_o, wbf_o;
  logic [TRC_ADDR_W-1:0] addr;
  logic [TRC_DATA_W-1:0] wdata, rdata;
  logic [TRC_CNT_W-1:0] cnt_o;
  int bad_count = 0;
  int cmp_count = 0;
  trc_top u_trc_top (.CLK(clk), .NRST(nrst), .ADDR(addr), .WDATA(wdata),
    .WR(wr_en), .RD(rd_en), .RDATA(rdata), .COUNT_TICK(tick_in),
    .IDLE_MODE(idle_in), .SYNC_START(sync_in), .COUNTER_RUN(run_o),
    .PRESCALER_RUN(prun_o), .DOUBLE_BUFFER_EN(wbf_o), .COUNT_VALUE(cnt_o));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
    end
  endtask
  // packs run, prescaler, buffer flags above the count
  task automatic outs(input logic [31:0] exp);
    chk({13'h0000, run_o, prun_o, wbf_o, cnt_o}, exp);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr_en <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr_en <= 1'b0;
    @(negedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd_en <= 1'b0;
    @(negedge clk);
    chk(rdata, exp);
  endtask
  // ticks spaced out so the strobe never changes twice in one step
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge clk);
      tick_in <= 1'b1;
      @(posedge clk);
      tick_in <= 1'b0;
    end
    repeat (2) @(negedge clk);
  endtask
  task automatic t_base;
    @(negedge clk);
    outs(TRC_ZERO);
    wr(TRC_OFS_RUN, 32'h0000_0001);
    outs(TRC_ZERO);
    wr(TRC_OFS_ENABLE, 32'h0000_0001);
    rd(TRC_OFS_RUN, TRC_ZERO);
    rd(TRC_OFS_CONFIG, TRC_ZERO);
    rd(8'h40, TRC_ZERO);
    $display("base done");
  endtask
  task automatic t_run;
    wr(TRC_OFS_RUN, 32'hFFFF_FFFF);
    rd(TRC_OFS_RUN, 32'h0000_0005);
    tick(5);
    outs(32'h0006_0005);
    wr(TRC_OFS_RUN, TRC_ZERO);
    rd(TRC_OFS_UPCNT, 32'h0000_0005);
    tick(2);
    outs(TRC_ZERO);
    $display("run done");
  endtask
  task automatic t_sync;
    wr(TRC_OFS_CONFIG, 32'hFFFF_FFBF);
    rd(TRC_OFS_CONFIG, 32'h0000_00A8);
    wr(TRC_OFS_CONFIG, 32'h0000_00A0);
    wr(TRC_OFS_RUN, 32'h0000_0001);
    tick(2);
    outs(32'h0005_0000);
    @(posedge clk);
    sync_in <= 1'b1;
    @(posedge clk);
    sync_in <= 1'b0;
    tick(3);
    outs(32'h0005_0003);
    rd(TRC_OFS_UPCNT, 32'h0000_0003);
    wr(TRC_OFS_RUN, TRC_ZERO);
    $display("sync done");
  endtask
  task automatic t_idle;
    wr(TRC_OFS_CONFIG, TRC_ZERO);
    @(posedge clk);
    idle_in <= 1'b1;
    wr(TRC_OFS_RUN, 32'h0000_0005);
    tick(2);
    outs(32'h0004_0000);
    wr(TRC_OFS_CONFIG, 32'h0000_0008);
    tick(2);
    outs(32'h0006_0002);
    wr(TRC_OFS_RUN, TRC_ZERO);
    $display("idle done");
  endtask
  task automatic t_keep;
    wr(TRC_OFS_CONFIG, 32'h0000_0080);
    wr(TRC_OFS_MODE, 32'h0000_0003);
    wr(TRC_OFS_ENABLE, TRC_ZERO);
    wr(TRC_OFS_CONFIG, TRC_ZERO);
    wr(TRC_OFS_MODE, TRC_ZERO);
    rd(TRC_OFS_CONFIG, TRC_ZERO);
    rd(TRC_OFS_MODE, TRC_ZERO);
    wr(TRC_OFS_ENABLE, 32'h0000_0001);
    rd(TRC_OFS_CONFIG, 32'h0000_0080);
    rd(TRC_OFS_MODE, 32'h0000_0023);
    $display("keep done");
  endtask
  task automatic t_reset;
    wr(TRC_OFS_CONFIG, 32'h0000_00A8);
    wr(TRC_OFS_RUN, 32'h0000_0005);
    outs(32'h0007_0000);
    @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    @(negedge clk);
    outs(TRC_ZERO);
    wr(TRC_OFS_ENABLE, 32'h0000_0001);
    rd(TRC_OFS_RUN, TRC_ZERO);
    rd(TRC_OFS_CONFIG, TRC_ZERO);
    $display("reset done");
  endtask
  initial begin
    #100000;
    bad_count++;
    wrap_up();
  end
  initial begin
    nrst = 1'b0;
    {wr_en, rd_en, tick_in, idle_in, sync_in} = 5'h00;
    addr = 8'h00;
    wdata = TRC_ZERO;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    t_base();
    t_run();
    t_sync();
    t_idle();
    t_keep();
    t_reset();
    wrap_up();
  end
endmodule
